// [src/cst_pkg.sv]
package cst_pkg;
  // =====================================================================
  // register addresses
  localparam logic [31:0] CST_DIV_ADDR    = 32'hffffe108;
  localparam logic [31:0] CST_CTRL_ADDR   = 32'hffffe100;
  localparam logic [31:0] CST_NINT_ADDR   = 32'hffffe104;
  localparam logic [31:0] CST_TOUT_ADDR   = 32'hffffe10c;
  localparam logic [31:0] CST_STAT_ADDR   = 32'hffffe110;
  localparam logic [31:0] CST_FINT_ADDR   = 32'hffffe114;
  localparam logic [31:0] CST_CUR_ADDR    = 32'hffffe118;
  localparam logic [31:0] CST_IMASK_ADDR  = 32'hffffe11c;
  // =====================================================================
  // control fields
  localparam int CST_CTRL_START   = 0;
  localparam int CST_CTRL_RESTART = 1;
  localparam int CST_CTRL_ALL     = 2;
  // status fields
  localparam int CST_ST_DONE = 0;
  localparam int CST_ST_FAIL = 1;
  localparam int CST_ST_TOUT = 2;
  localparam int CST_ST_RST  = 3;
  localparam int CST_NSTAT   = 4;
  // =====================================================================
  // numbers
  localparam int CST_CYC_PER_INT = 1365;
  localparam int CST_MAX_INT     = 26;
  localparam int CST_DIV_MAX     = 8;
  localparam logic [2:0] CST_DIV_RST = 3'h0;
  localparam logic [31:0] CST_TOUT_RST = 32'hffffffff;
  localparam logic [1:0] CST_RESP_OK  = 2'h0;
  localparam logic [1:0] CST_RESP_ERR = 2'h2;
  typedef enum logic [1:0] {CST_IDLE, CST_RUN, CST_CHECK, CST_RESET} cst_state_t;
endpackage

// [src/cst_divide_ratio_field.sv]
// =====================================================================
// enable-pulse divider: one tick every (i_div+1) core clocks
module cst_tick_div
  import cst_pkg::*;
(
  input  wire logic       I_CLK,  // core clock
  input  wire logic       I_RSTN, // async reset, low
  input  wire logic       i_run,  // divider active
  input  wire logic [2:0] i_div,  // ratio minus one
  output logic            o_tick  // self-test clock tick
);
  typedef struct packed {
    logic [2:0] cnt;
  } cst_div_t;
  cst_div_t s_q, s_d;
  always_comb begin
    s_d    = s_q;
    o_tick = 1'b0;
    if (!i_run) begin
      s_d.cnt = 3'h0;
    end else if (s_q.cnt >= i_div) begin
      s_d.cnt = 3'h0;
      o_tick  = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) s_q <= '0;
    else s_q <= s_d;
  end
endmodule

// [src/cst_ctrl.sv]
// Function
// - the controller drives the logic self-test engine on both cores and checks its result.
// - the test is split into intervals and a run covers all or a programmed count of them.
// - each run resumes after the last executed interval or restarts at the first, per software.
// - the core under test is isolated from the system for the whole run.
// - the number of a failing interval is captured and held for software.
// - a timeout counter loaded from software bounds each run.
// - a run ends with a CPU reset and software reads status in the reset handler.
// - the self-test clock is divided from the CPU clock by a register-held divider.
// - each interval takes 1365 self-test clock cycles, for up to 26 intervals.
// - run length is cycle count times the self-test clock period, timed by the timeout.
// - the divider ratio is 1 to 8 and applies alike to the delayed second core clock.
// - a controller-caused CPU reset is flagged as its own reset cause.
//
// Our own choice: the AXI4-Lite slave port.
module cst_ctrl
  import cst_pkg::*;
#(
  parameter int NUM_INT = CST_MAX_INT,     // intervals in the full test
  parameter int CYC_INT = CST_CYC_PER_INT  // self-test cycles per interval
) (
  input  wire logic        I_CLK,          // core clock, 20 MHz
  input  wire logic        I_RSTN,         // async reset, low
  input  wire logic [31:0] I_AWADDR,       // axi write address
  input  wire logic        I_AWVALID,      // axi write address valid
  output logic             O_AWREADY,      // axi write address ready
  input  wire logic [31:0] I_WDATA,        // axi write data
  input  wire logic [3:0]  I_WSTRB,        // axi byte strobes
  input  wire logic        I_WVALID,       // axi write data valid
  output logic             O_WREADY,       // axi write data ready
  output logic [1:0]       O_BRESP,        // axi write response
  output logic             O_BVALID,       // axi write response valid
  input  wire logic        I_BREADY,       // axi write response ready
  input  wire logic [31:0] I_ARADDR,       // axi read address
  input  wire logic        I_ARVALID,      // axi read address valid
  output logic             O_ARREADY,      // axi read address ready
  output logic [31:0]      O_RDATA,        // axi read data
  output logic [1:0]       O_RRESP,        // axi read response
  output logic             O_RVALID,       // axi read data valid
  input  wire logic        I_RREADY,       // axi read data ready
  input  wire logic        I_BIST_DONE,    // engine finished current interval
  input  wire logic        I_BIST_PASS,    // engine signature matched
  output logic             O_BIST_EN,      // engine runs, one tick per self-test clock
  output logic [4:0]       O_BIST_INT,     // interval number being applied
  output logic             O_CORE_ISOLATE, // core cut off from buses
  output logic [2:0]       O_CLK_DIV,      // ratio for both core clock trees
  output logic             O_CPU_RST,      // cpu reset request pulse
  output logic             O_RST_CAUSE,    // self-test reset cause flag
  output logic             O_IRQ           // level interrupt
);
  // =====================================================================
  // parameter check
  initial begin
    if (NUM_INT < 1 || NUM_INT > CST_MAX_INT) $error("cst_ctrl: bad NUM_INT");
    if (CYC_INT < 1 || CYC_INT > 65535) $error("cst_ctrl: bad CYC_INT");
  end

  localparam logic [15:0] CYC_LAST = 16'(CYC_INT - 1);
  localparam logic [4:0]  INT_ALL  = 5'(NUM_INT);

  // =====================================================================
  // address decode, shared by the write and read channels
  function automatic logic [3:0] dec(input logic [31:0] a);
    unique case (a)
      CST_CTRL_ADDR:   dec = 4'h1;
      CST_NINT_ADDR:   dec = 4'h2;
      CST_DIV_ADDR:    dec = 4'h3;
      CST_TOUT_ADDR:   dec = 4'h4;
      CST_STAT_ADDR:   dec = 4'h5;
      CST_FINT_ADDR:   dec = 4'h6;
      CST_CUR_ADDR:    dec = 4'h7;
      CST_IMASK_ADDR:  dec = 4'h8;
      default:         dec = 4'h0;
    endcase
  endfunction

  // unmapped addresses answer with a slave error
  function automatic logic [1:0] resp_of(input logic [3:0] sel);
    if (sel == 4'h0) begin
      resp_of = CST_RESP_ERR;
    end else begin
      resp_of = CST_RESP_OK;
    end
  endfunction

  // =====================================================================
  // interval helpers
  // interval to apply after c, back to the first once the full test has run
  function automatic logic [4:0] nxt_int(input logic [4:0] c);
    if (c + 5'h1 >= INT_ALL) begin
      nxt_int = 5'h0;
    end else begin
      nxt_int = c + 5'h1;
    end
  endfunction

  // intervals in one run: the full test unless run-all is clear and a usable count is programmed
  function automatic logic [4:0] run_len(input logic all, input logic [4:0] n);
    if (all || n == 5'h0 || n > INT_ALL) begin
      run_len = INT_ALL;
    end else begin
      run_len = n;
    end
  endfunction

  // status raised when the timeout cuts a run short
  function automatic logic [CST_NSTAT-1:0] tout_ev();
    tout_ev              = '0;
    tout_ev[CST_ST_TOUT] = 1'b1;
    tout_ev[CST_ST_FAIL] = 1'b1;
  endfunction

  // =====================================================================
  // state
  typedef struct packed {
    cst_state_t      st;
    // bus channel holding
    logic            aw_h;
    logic [31:0]     awaddr;
    logic            w_h;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    // software settings
    logic            restart;
    logic            all;
    logic [4:0]      nint;
    logic [2:0]      div;
    logic [31:0]     tout;
    // run progress and results
    logic [31:0]     tcnt;
    logic [CST_NSTAT-1:0] stat;
    logic [CST_NSTAT-1:0] imask;
    logic [4:0]      fint;
    logic [4:0]      cur;
    logic [4:0]      left;
    logic [15:0]     cyc;
    logic            cpu_rst;
  } cst_regs_t;

  cst_regs_t s_q, s_d;
  logic      tick;

  // =====================================================================
  // self-test clock divider
  cst_tick_div u_div (
    .I_CLK  (I_CLK),
    .I_RSTN (I_RSTN),
    .i_run  (s_q.st == CST_RUN),
    .i_div  (s_q.div),
    .o_tick (tick)
  );

  // =====================================================================
  // outputs
  assign O_AWREADY      = !s_q.aw_h;
  assign O_WREADY       = !s_q.w_h;
  assign O_BVALID       = s_q.bvalid;
  assign O_BRESP        = s_q.bresp;
  assign O_ARREADY      = !s_q.rvalid;
  assign O_RVALID       = s_q.rvalid;
  assign O_RDATA        = s_q.rdata;
  assign O_RRESP        = s_q.rresp;
  assign O_BIST_EN      = tick;
  assign O_BIST_INT     = s_q.cur;
  assign O_CORE_ISOLATE = (s_q.st != CST_IDLE);
  assign O_CLK_DIV      = s_q.div;
  assign O_CPU_RST      = s_q.cpu_rst;
  assign O_RST_CAUSE    = s_q.stat[CST_ST_RST];
  assign O_IRQ          = |(s_q.stat & s_q.imask);

  // =====================================================================
  // next state
  always_comb begin
    logic [3:0]           wsel;
    logic [3:0]           rsel;
    logic                 do_wr;
    logic                 do_rd;
    logic                 start;
    logic [CST_NSTAT-1:0] ev;
    logic [CST_NSTAT-1:0] rdclr;
    wsel  = 4'h0;
    rsel  = 4'h0;
    do_wr = 1'b0;
    do_rd = 1'b0;
    start = 1'b0;
    ev    = '0;
    rdclr = '0;
    s_d   = s_q;
    s_d.cpu_rst = 1'b0;

    // =====================================================================
    // write channel capture, either order
    if (I_AWVALID && !s_q.aw_h) begin
      s_d.aw_h   = 1'b1;
      s_d.awaddr = I_AWADDR;
    end
    if (I_WVALID && !s_q.w_h) begin
      s_d.w_h   = 1'b1;
      s_d.wdata = I_WDATA;
      s_d.wstrb = I_WSTRB;
    end
    if (s_q.bvalid && I_BREADY) s_d.bvalid = 1'b0;
    if (s_q.aw_h && s_q.w_h && !s_q.bvalid) begin
      do_wr      = 1'b1;
      wsel       = dec(s_q.awaddr);
      s_d.aw_h   = 1'b0;
      s_d.w_h    = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = resp_of(wsel);
    end

    // =====================================================================
    // register writes, low byte lane holds all fields but the timeout, which takes each enabled lane
    if (do_wr && s_q.wstrb[0]) begin
      unique case (wsel)
        4'h1: begin
          s_d.restart = s_q.wdata[CST_CTRL_RESTART];
          s_d.all     = s_q.wdata[CST_CTRL_ALL];
          start       = s_q.wdata[CST_CTRL_START] && (s_q.st == CST_IDLE);
        end
        4'h2: s_d.nint = s_q.wdata[4:0];
        4'h3: begin
          if (s_q.st == CST_IDLE) s_d.div = s_q.wdata[2:0];
        end
        4'h5: rdclr = s_q.wdata[CST_NSTAT-1:0];
        4'h8: s_d.imask = s_q.wdata[CST_NSTAT-1:0];
        default: ;
      endcase
    end
    if (do_wr && wsel == 4'h4) begin
      for (int b = 0; b < 4; b++) begin
        if (s_q.wstrb[b]) s_d.tout[b*8 +: 8] = s_q.wdata[b*8 +: 8];
      end
    end

    // =====================================================================
    // read channel
    if (s_q.rvalid && I_RREADY) s_d.rvalid = 1'b0;
    if (I_ARVALID && !s_q.rvalid) begin
      do_rd      = 1'b1;
      rsel       = dec(I_ARADDR);
      s_d.rvalid = 1'b1;
      s_d.rresp  = resp_of(rsel);
      s_d.rdata  = 32'h0;
      unique case (rsel)
        4'h1: begin
          s_d.rdata[CST_CTRL_RESTART] = s_q.restart;
          s_d.rdata[CST_CTRL_ALL]     = s_q.all;
          s_d.rdata[CST_CTRL_START]   = (s_q.st != CST_IDLE);
        end
        4'h2: s_d.rdata[4:0] = s_q.nint;
        4'h3: s_d.rdata[2:0] = s_q.div;
        4'h4: s_d.rdata = s_q.tout;
        4'h5: begin
          s_d.rdata[CST_NSTAT-1:0] = s_q.stat;
          rdclr = rdclr | s_q.stat;
        end
        4'h6: s_d.rdata[4:0] = s_q.fint;
        4'h7: s_d.rdata[4:0] = s_q.cur;
        4'h8: s_d.rdata[CST_NSTAT-1:0] = s_q.imask;
        default: ;
      endcase
    end

    // =====================================================================
    // sequencer
    unique case (s_q.st)
      CST_IDLE: begin
        if (start) begin
          s_d.st   = CST_RUN;
          s_d.tcnt = s_q.tout;
          s_d.cyc  = 16'h0;
          // restart and run-all come from the same write as the start bit
          if (s_d.restart || s_q.cur >= INT_ALL) s_d.cur = 5'h0;
          s_d.left = run_len(s_d.all, s_q.nint);
        end
      end
      CST_RUN: begin
        if (s_q.tcnt == 32'h0) begin
          ev     = ev | tout_ev();
          s_d.st = CST_RESET;
        end else begin
          s_d.tcnt = s_q.tcnt - 32'h1;
          if (tick) begin
            s_d.cyc = s_q.cyc + 16'h1;
            if (s_q.cyc == CYC_LAST) s_d.st = CST_CHECK;
          end
        end
      end
      CST_CHECK: begin
        if (I_BIST_DONE) begin
          s_d.cyc  = 16'h0;
          s_d.cur  = nxt_int(s_q.cur);
          s_d.left = s_q.left - 5'h1;
          if (!I_BIST_PASS) begin
            ev[CST_ST_FAIL] = 1'b1;
            s_d.fint = s_q.cur + 5'h1;
            s_d.st   = CST_RESET;
          end else if (s_q.left == 5'h1 || s_q.cur + 5'h1 >= INT_ALL) begin
            s_d.st = CST_RESET;
          end else begin
            s_d.st = CST_RUN;
          end
        end else if (s_q.tcnt == 32'h0) begin
          ev     = ev | tout_ev();
          s_d.st = CST_RESET;
        end else begin
          s_d.tcnt = s_q.tcnt - 32'h1;
        end
      end
      CST_RESET: begin
        ev[CST_ST_DONE] = 1'b1;
        ev[CST_ST_RST]  = 1'b1;
        s_d.cpu_rst     = 1'b1;
        s_d.st          = CST_IDLE;
      end
    endcase

    // =====================================================================
    // sticky status, set wins over clear
    s_d.stat = (s_q.stat & ~rdclr) | ev;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s_q      <= '0;
      s_q.st   <= CST_IDLE;
      s_q.div  <= CST_DIV_RST;
      s_q.tout <= CST_TOUT_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [tb/cst_engine_model.sv]
// =====================================================================
// behavioural self-test engine: finishes an interval after CYC ticks
module cst_engine_model #(
  parameter int CYC = 4  // ticks per interval
) (
  input  wire logic       i_clk,   // core clock
  input  wire logic       i_rstn,  // reset, low
  input  wire logic       i_tick,  // self-test clock tick
  input  wire logic [4:0] i_int,   // interval under test
  input  wire logic       i_iso,   // run in progress
  input  wire logic       i_stall, // never finish
  input  wire logic [4:0] i_bad,   // interval whose signature fails
  output logic            o_done,  // interval finished
  output logic            o_pass   // signature matched
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt;
  logic [4:0] last;
  logic       fin;
  assign fin = i_iso && !i_stall && cnt >= CYC && i_int == last;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt    <= 0;
      last   <= 5'h0;
      o_done <= 1'b0;
      o_pass <= 1'b0;
    end else begin
      last   <= i_int;
      // a tick in the first cycle of a new interval already belongs to it
      cnt    <= (!i_iso || i_int != last) ? int'(i_tick) : cnt + int'(i_tick);
      o_done <= fin;
      // pass toggles while not qualified so no stale value is seen
      o_pass <= fin ? (i_int != i_bad) : ~o_pass;
    end
  end
endmodule

// [tb/cst_ctrl_asserts.sv]
module cst_ctrl_chk
  import cst_pkg::*;
#(
  parameter int NUM_INT = CST_MAX_INT  // intervals in the full test
) (
  input wire logic        I_CLK,          // core clock
  input wire logic        I_RSTN,         // reset, low
  input wire logic        I_BREADY,       // write response ready
  input wire logic        O_BVALID,       // write response valid
  input wire logic [1:0]  O_BRESP,        // write response
  input wire logic        I_RREADY,       // read data ready
  input wire logic        O_RVALID,       // read data valid
  input wire logic [31:0] O_RDATA,        // read data
  input wire logic        O_ARREADY,      // read address ready
  input wire logic        O_BIST_EN,      // engine tick
  input wire logic [4:0]  O_BIST_INT,     // interval number
  input wire logic        O_CORE_ISOLATE, // core cut off
  input wire logic [2:0]  O_CLK_DIV,      // divide ratio
  input wire logic        O_CPU_RST,      // cpu reset pulse
  input wire logic        O_RST_CAUSE     // reset cause flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  iso_tick_a: assert property (O_BIST_EN |-> O_CORE_ISOLATE)
    else $error("tick outside isolation");
  int_bound_a: assert property (O_CORE_ISOLATE |-> O_BIST_INT < NUM_INT)
    else $error("interval number out of range");
  rst_pulse_a: assert property ($rose(O_CPU_RST) |=> !O_CPU_RST)
    else $error("cpu reset longer than one cycle");
  rst_cause_a: assert property (O_CPU_RST |-> O_RST_CAUSE && !O_CORE_ISOLATE)
    else $error("cpu reset without cause flag");
  div_hold_a: assert property (O_CORE_ISOLATE && $past(O_CORE_ISOLATE) |-> $stable(O_CLK_DIV))
    else $error("divider changed during run");
  tick_gap_a: assert property (O_BIST_EN && O_CLK_DIV == 3'h7 |=> !O_BIST_EN [*7])
    else $error("ticks too close for ratio");
  bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  ar_block_a: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read address taken while answering");
  cover property (O_CPU_RST && O_RST_CAUSE);
  cover property (O_BIST_EN && O_CLK_DIV == 3'h7);
  cover property (O_RVALID && !I_RREADY);
endmodule
bind cst_ctrl cst_ctrl_chk #(.NUM_INT(NUM_INT)) u_chk (.I_CLK, .I_RSTN, .I_BREADY, .O_BVALID,
  .O_BRESP, .I_RREADY, .O_RVALID, .O_RDATA, .O_ARREADY, .O_BIST_EN, .O_BIST_INT,
  .O_CORE_ISOLATE, .O_CLK_DIV, .O_CPU_RST, .O_RST_CAUSE);

// [tb/cst_ctrl_tb.sv]
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module cst_ctrl_tb;
  import cst_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 4;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, stall;
  logic        awready, wready, bvalid, arready, rvalid, done, pass, en, iso, rst, cause, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [4:0]  bad, lint;
  logic [2:0]  div;
  logic [1:0]  bresp, rresp, resp;
  int          n_fail, n_tests, ticks;
  cst_ctrl #(.NUM_INT(CST_MAX_INT), .CYC_INT(CYC)) dut (.I_CLK(clk), .I_RSTN(rstn),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_BIST_DONE(done), .I_BIST_PASS(pass), .O_BIST_EN(en), .O_BIST_INT(lint),
    .O_CORE_ISOLATE(iso), .O_CLK_DIV(div), .O_CPU_RST(rst), .O_RST_CAUSE(cause), .O_IRQ(irq));
  cst_engine_model #(.CYC(CYC)) u_eng (.i_clk(clk), .i_rstn(rstn), .i_tick(en), .i_int(lint),
    .i_iso(iso), .i_stall(stall), .i_bad(bad), .o_done(done), .o_pass(pass));
  // =====================================================================
  // bus tasks: ready is sampled mid-cycle, signals move after the edge
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    resp = 2'bxx;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bready && bvalid;
      if (hb) resp = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      if (hb) break;
    end
    @(posedge clk);
    `CHK("bresp", CST_RESP_OK, resp)
  endtask
  task automatic rd(input logic [31:0] a);
    logic ha, hb;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 'x;
    resp = 2'bxx;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      ha = arvalid && arready;
      hb = rready && rvalid;
      if (hb) d = rdata;
      if (hb) resp = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hb) rready <= 1'b0;
      if (hb) break;
    end
    @(posedge clk);
  endtask
  task automatic wait_rst();
    for (int n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (rst) break;
    end
    `CHK("cpu reset", 1'b1, rst)
    `CHK("cause", 1'b1, cause)
    `CHK("released", 1'b0, iso)
    @(posedge clk);
  endtask
  // =====================================================================
  // scenarios
  task automatic t_regs();
    rd(CST_DIV_ADDR);
    `CHK("div reset", 32'h0, d)
    rd(CST_TOUT_ADDR);
    `CHK("tout reset", CST_TOUT_RST, d)
    rd(32'hffffe120);
    `CHK("unmapped", CST_RESP_ERR, resp)
    wr(CST_DIV_ADDR, 32'h1);
    `CHK("div out", 3'h1, div)
    $display("t_regs done");
  endtask
  task automatic t_pass();
    wr(CST_TOUT_ADDR, 32'h1000);
    wr(CST_NINT_ADDR, 32'h2);
    ticks = 0;
    wr(CST_CTRL_ADDR, 32'h3);
    `CHK("isolate", 1'b1, iso)
    wait_rst();
    `CHK("ticks", 2 * CYC, ticks)
    `CHK("irq masked", 1'b0, irq)
    rd(CST_STAT_ADDR);
    `CHK("status", 32'h9, d)
    rd(CST_CUR_ADDR);
    `CHK("next int", 32'h2, d)
    rd(CST_STAT_ADDR);
    `CHK("cleared", 32'h0, d)
    $display("t_pass done");
  endtask
  task automatic t_resume();
    wr(CST_DIV_ADDR, 32'h7);
    wr(CST_NINT_ADDR, 32'h1);
    ticks = 0;
    wr(CST_CTRL_ADDR, 32'h1);
    `CHK("resumed int", 5'h2, lint)
    wr(CST_DIV_ADDR, 32'h3);
    wait_rst();
    `CHK("ticks", CYC, ticks)
    rd(CST_DIV_ADDR);
    `CHK("div kept", 32'h7, d)
    rd(CST_STAT_ADDR);
    `CHK("status", 32'h9, d)
    $display("t_resume done");
  endtask
  task automatic t_fail();
    wr(CST_DIV_ADDR, 32'h0);
    wr(CST_IMASK_ADDR, 32'h2);
    bad <= 5'h1;
    wr(CST_NINT_ADDR, 32'h3);
    wr(CST_CTRL_ADDR, 32'h3);
    wait_rst();
    `CHK("irq", 1'b1, irq)
    rd(CST_FINT_ADDR);
    `CHK("fail int", 32'h2, d)
    rd(CST_STAT_ADDR);
    `CHK("fail bit", 1'b1, d[CST_ST_FAIL])
    `CHK("irq cleared", 1'b0, irq)
    bad <= 5'h1f;
    $display("t_fail done");
  endtask
  task automatic t_tout();
    stall <= 1'b1;
    wr(CST_TOUT_ADDR, 32'h28);
    wr(CST_CTRL_ADDR, 32'h3);
    wait_rst();
    rd(CST_STAT_ADDR);
    `CHK("tout bit", 1'b1, d[CST_ST_TOUT])
    `CHK("rst bit", 1'b1, d[CST_ST_RST])
    stall <= 1'b0;
    $display("t_tout done");
  endtask
  task automatic t_all();
    wr(CST_TOUT_ADDR, 32'h1000);
    ticks = 0;
    wr(CST_CTRL_ADDR, 32'h7);
    wait_rst();
    `CHK("ticks", CST_MAX_INT * CYC, ticks)
    rd(CST_STAT_ADDR);
    `CHK("status", 32'h9, d)
    $display("t_all done");
  endtask
  task automatic conclude();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // =====================================================================
  always @(negedge clk) if (en) ticks++;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, stall} = '0;
    {awaddr, wdata, araddr} = '0;
    bad = 5'h1f;
    n_fail = 0;
    n_tests = 0;
    ticks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_pass();
    t_resume();
    t_fail();
    t_tout();
    t_all();
    conclude();
  end
endmodule
